// >>> usb_susp_pkg.sv
// Operation
// - suspended status set on suspend entry
// - writing force resume zero while force resume is set clears suspended
// - reading common flags after resume clears suspended
// - detect disabled: suspend signaling ignored
// - detect enabled and inhibit clear: suspend signaling enters suspend
// - frame low register returns bits 7:0
// - frame high register returns bits 10:8
// - frame high upper bits read zero
// - pending flags are read only
// - interrupt asserts when any flag set
// - interrupt also gated by cpu enable
// - reading a flag register clears only that register's flags
// - in flag bits 3:1 are endpoints 3:1
// - bit 0 is control endpoint flag
// - in flag bits 7:4 read zero
// - resume flag set on resume while suspended
// - suspend flag set only when detect enabled
// - inhibit set after reset until cleared
package usb_susp_pkg;
    localparam logic [11:0] power_off        = 12'h004;
    localparam logic [11:0] frame_low_off    = 12'h00c;
    localparam logic [11:0] frame_high_off   = 12'h010;
    localparam logic [11:0] in_flags_off     = 12'h014;
    localparam logic [11:0] common_flags_off = 12'h018;
    localparam logic [11:0] irq_status_off   = 12'h01c;
    localparam logic [11:0] irq_mask_off     = 12'h020;
    localparam int          power_inhibit_bit = 4;
    localparam int          power_resume_bit  = 2;
    localparam int          power_susp_bit    = 1;
    localparam int          power_detect_bit  = 0;
    localparam int          cm_resume_bit     = 1;
    localparam int          cm_suspend_bit    = 0;
    localparam logic [7:0]  power_reset      = 8'h10;
    localparam logic [31:0] unmapped_value   = 32'h0000_0000;

    typedef struct packed {
        logic        inhibit;
        logic        force_resume;
        logic        suspended;
        logic        detect_en;
        logic [10:0] frame;
        logic [3:0]  in_flags;
        logic [1:0]  common_flags;
        logic [1:0]  irq_status;
        logic [1:0]  irq_mask;
        logic [31:0] prdata;
        logic        pready;
        logic        pslverr;
        logic        irq;
        logic        usb_irq;
    } state_t;

    typedef struct packed {
        logic        suspend_seen;
        logic        resume_seen;
        logic        frame_valid;
        logic [10:0] frame_number;
        logic [3:0]  in_events;
    } link_in_t;
endpackage

// >>> usb_susp_frame_irq.sv
// The APB slave port was left to the implementer.
module usb_susp_frame_irq (
    input  wire logic                    core_clk,
    input  wire logic                    arst_n,
    input  wire logic                    psel,
    input  wire logic                    penable,
    input  wire logic                    pwrite,
    input  wire logic [11:0]             paddr,
    input  wire logic [31:0]             pwdata,
    output logic      [31:0]             prdata,
    output logic                         pready,
    output logic                         pslverr,
    input  wire usb_susp_pkg::link_in_t  link_in,
    input  wire logic                    cpu_extended_irq_enable,
    output logic                         usb_irq,
    output logic                         resume_drive,
    output logic                         controller_inhibit,
    output logic                         irq
);
    usb_susp_pkg::state_t s_q;
    usb_susp_pkg::state_t s_d;
    usb_susp_pkg::link_in_t lk;
    logic wr;
    logic rd;
    logic susp_ev;
    logic res_ev;
    logic rd_common;
    logic rd_in;

    // link inputs come from same-clock usb logic, so no synchroniser
    assign lk = link_in;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
        hit = (a == o);
    endfunction

    always_comb begin
        wr = psel && penable && !s_q.pready && pwrite;
        rd = psel && penable && !s_q.pready && !pwrite;
        susp_ev = lk.suspend_seen && s_q.detect_en && !s_q.inhibit;
        res_ev = lk.resume_seen && s_q.suspended && !s_q.inhibit;
        rd_common = rd && hit(paddr, usb_susp_pkg::common_flags_off);
        rd_in = rd && hit(paddr, usb_susp_pkg::in_flags_off);
        s_d = s_q;
        s_d.pready = psel && penable && !s_q.pready;
        s_d.pslverr = 1'b0;
        s_d.prdata = usb_susp_pkg::unmapped_value;
        if (rd) begin
            unique case (paddr)
                usb_susp_pkg::power_off: begin
                    s_d.prdata[usb_susp_pkg::power_inhibit_bit] = s_q.inhibit;
                    s_d.prdata[usb_susp_pkg::power_resume_bit] = s_q.force_resume;
                    s_d.prdata[usb_susp_pkg::power_susp_bit] = s_q.suspended;
                    s_d.prdata[usb_susp_pkg::power_detect_bit] = s_q.detect_en;
                end
                usb_susp_pkg::frame_low_off: s_d.prdata[7:0] = s_q.frame[7:0];
                usb_susp_pkg::frame_high_off: s_d.prdata[2:0] = s_q.frame[10:8];
                usb_susp_pkg::in_flags_off: s_d.prdata[3:0] = s_q.in_flags;
                usb_susp_pkg::common_flags_off: s_d.prdata[1:0] = s_q.common_flags;
                usb_susp_pkg::irq_status_off: s_d.prdata[1:0] = s_q.irq_status;
                usb_susp_pkg::irq_mask_off: s_d.prdata[1:0] = s_q.irq_mask;
                default: s_d.pslverr = 1'b1;
            endcase
        end
        if (wr) begin
            unique case (paddr)
                usb_susp_pkg::power_off: begin
                    // software may clear inhibit but never set it
                    if (!pwdata[usb_susp_pkg::power_inhibit_bit])
                        s_d.inhibit = 1'b0;
                    s_d.force_resume = pwdata[usb_susp_pkg::power_resume_bit] && s_q.suspended;
                    if (s_q.force_resume && !pwdata[usb_susp_pkg::power_resume_bit])
                        s_d.suspended = 1'b0;
                    s_d.detect_en = pwdata[usb_susp_pkg::power_detect_bit];
                end
                usb_susp_pkg::irq_status_off: s_d.irq_status = s_q.irq_status & ~pwdata[1:0];
                usb_susp_pkg::irq_mask_off: s_d.irq_mask = pwdata[1:0];
                // flag and frame registers ignore writes
                usb_susp_pkg::frame_low_off, usb_susp_pkg::frame_high_off,
                usb_susp_pkg::in_flags_off, usb_susp_pkg::common_flags_off: ;
                default: s_d.pslverr = 1'b1;
            endcase
        end
        if (rd_common && s_q.common_flags[usb_susp_pkg::cm_resume_bit])
            s_d.suspended = 1'b0;
        if (rd_common)
            s_d.common_flags = 2'b00;
        if (rd_in)
            s_d.in_flags = 4'h0;
        // set after clear so a simultaneous event survives
        if (susp_ev) begin
            s_d.suspended = 1'b1;
            s_d.common_flags[usb_susp_pkg::cm_suspend_bit] = 1'b1;
        end
        if (res_ev)
            s_d.common_flags[usb_susp_pkg::cm_resume_bit] = 1'b1;
        if (!s_q.inhibit)
            s_d.in_flags = s_d.in_flags | lk.in_events;
        if (lk.frame_valid && !s_q.inhibit)
            s_d.frame = lk.frame_number;
        if (!s_d.suspended)
            s_d.force_resume = 1'b0;
        s_d.irq_status = s_d.irq_status | {res_ev, susp_ev};
        s_d.irq = |(s_d.irq_status & s_d.irq_mask);
        s_d.usb_irq = ((|s_d.in_flags) || (|s_d.common_flags))
                      && cpu_extended_irq_enable;
    end

    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.inhibit <= usb_susp_pkg::power_reset[usb_susp_pkg::power_inhibit_bit];
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign usb_irq = s_q.usb_irq;
    assign resume_drive = s_q.force_resume;
    assign controller_inhibit = s_q.inhibit;
    assign irq = s_q.irq;

    property p_susp_enter;
        @(posedge core_clk) disable iff (!arst_n)
        (link_in.suspend_seen && s_q.detect_en && !s_q.inhibit) |=> s_q.suspended;
    endproperty
    a_susp_enter: assert property (p_susp_enter) else $error("suspend not entered");

    property p_no_susp;
        @(posedge core_clk) disable iff (!arst_n)
        (!s_q.detect_en && !s_q.suspended) |=> !$rose(s_q.common_flags[0]);
    endproperty
    a_no_susp: assert property (p_no_susp) else $error("suspend flag while disabled");

    property p_resume_clear;
        @(posedge core_clk) disable iff (!arst_n)
        (wr && paddr == usb_susp_pkg::power_off && s_q.force_resume && !pwdata[2]
         && !link_in.suspend_seen) |=> !s_q.suspended;
    endproperty
    a_resume_clear: assert property (p_resume_clear) else $error("suspend kept");

    property p_common_rd;
        @(posedge core_clk) disable iff (!arst_n)
        (rd_common && s_q.common_flags[1] && !link_in.suspend_seen) |=> !s_q.suspended;
    endproperty
    a_common_rd: assert property (p_common_rd) else $error("suspend not cleared");

    property p_frame_hi;
        @(posedge core_clk) disable iff (!arst_n)
        (rd && paddr == usb_susp_pkg::frame_high_off) |=> prdata[31:3] == 29'h0;
    endproperty
    a_frame_hi: assert property (p_frame_hi) else $error("frame high upper bits");

    property p_in_rd;
        @(posedge core_clk) disable iff (!arst_n)
        (rd_in && link_in.in_events == 4'h0) |=> s_q.in_flags == 4'h0 && prdata[31:4] == 28'h0;
    endproperty
    a_in_rd: assert property (p_in_rd) else $error("in flags not cleared");

    property p_irq;
        @(posedge core_clk) disable iff (!arst_n)
        ((|s_q.in_flags) && cpu_extended_irq_enable && !rd_in) |=> usb_irq;
    endproperty
    a_irq: assert property (p_irq) else $error("usb irq missing");

    property p_irq_gate;
        @(posedge core_clk) disable iff (!arst_n)
        !cpu_extended_irq_enable |=> !usb_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("usb irq not gated");

    property p_resume_flag;
        @(posedge core_clk) disable iff (!arst_n)
        (link_in.resume_seen && s_q.suspended && !s_q.inhibit) |=> s_q.common_flags[1];
    endproperty
    a_resume_flag: assert property (p_resume_flag) else $error("resume flag lost");

    property p_inhibit;
        @(posedge core_clk) disable iff (!arst_n)
        s_q.inhibit && !(wr && paddr == usb_susp_pkg::power_off) |=> s_q.inhibit;
    endproperty
    a_inhibit: assert property (p_inhibit) else $error("inhibit dropped");

    property p_ready_pulse;
        @(posedge core_clk) disable iff (!arst_n)
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("pready held");

    property p_ready_answer;
        @(posedge core_clk) disable iff (!arst_n)
        (psel && penable && !pready) |=> pready;
    endproperty
    a_ready_answer: assert property (p_ready_answer) else $error("pready missing");

    property p_err_ready;
        @(posedge core_clk) disable iff (!arst_n)
        pslverr |-> pready && prdata == 32'h0000_0000;
    endproperty
    a_err_ready: assert property (p_err_ready) else $error("pslverr outside response");

    property p_data_idle;
        @(posedge core_clk) disable iff (!arst_n)
        !pready |-> prdata == 32'h0000_0000;
    endproperty
    a_data_idle: assert property (p_data_idle) else $error("prdata outside response");

    property p_frame_lo_data;
        @(posedge core_clk) disable iff (!arst_n)
        (rd && paddr == usb_susp_pkg::frame_low_off)
            |=> prdata[7:0] == $past(s_q.frame[7:0]) && prdata[31:8] == 24'h00_0000;
    endproperty
    a_frame_lo_data: assert property (p_frame_lo_data) else $error("frame low data");

    property p_frame_hi_data;
        @(posedge core_clk) disable iff (!arst_n)
        (rd && paddr == usb_susp_pkg::frame_high_off)
            |=> prdata[2:0] == $past(s_q.frame[10:8]);
    endproperty
    a_frame_hi_data: assert property (p_frame_hi_data) else $error("frame high data");

    property p_frame_capture;
        @(posedge core_clk) disable iff (!arst_n)
        (link_in.frame_valid && !s_q.inhibit) |=> s_q.frame == $past(link_in.frame_number);
    endproperty
    a_frame_capture: assert property (p_frame_capture) else $error("frame not taken");

    property p_frame_hold;
        @(posedge core_clk) disable iff (!arst_n)
        !(link_in.frame_valid && !s_q.inhibit) |=> $stable(s_q.frame);
    endproperty
    a_frame_hold: assert property (p_frame_hold) else $error("frame changed");

    property p_in_capture;
        @(posedge core_clk) disable iff (!arst_n)
        !s_q.inhibit |=> (s_q.in_flags & $past(link_in.in_events)) == $past(link_in.in_events);
    endproperty
    a_in_capture: assert property (p_in_capture) else $error("in event lost");

    property p_in_read_data;
        @(posedge core_clk) disable iff (!arst_n)
        rd_in |=> prdata[3:0] == $past(s_q.in_flags) && prdata[31:4] == 28'h000_0000;
    endproperty
    a_in_read_data: assert property (p_in_read_data) else $error("in flags data");

    property p_in_hold;
        @(posedge core_clk) disable iff (!arst_n)
        (!rd_in && (s_q.inhibit || link_in.in_events == 4'h0)) |=> $stable(s_q.in_flags);
    endproperty
    a_in_hold: assert property (p_in_hold) else $error("in flags changed");

    property p_common_hold;
        @(posedge core_clk) disable iff (!arst_n)
        (!rd_common && !susp_ev && !res_ev) |=> $stable(s_q.common_flags);
    endproperty
    a_common_hold: assert property (p_common_hold) else $error("common flags changed");

    property p_common_clear;
        @(posedge core_clk) disable iff (!arst_n)
        (rd_common && !susp_ev && !res_ev) |=> s_q.common_flags == 2'b00;
    endproperty
    a_common_clear: assert property (p_common_clear) else $error("common not cleared");

    property p_common_data;
        @(posedge core_clk) disable iff (!arst_n)
        rd_common |=> prdata[1:0] == $past(s_q.common_flags) && prdata[31:2] == 30'h0000_0000;
    endproperty
    a_common_data: assert property (p_common_data) else $error("common flags data");

    property p_susp_flag;
        @(posedge core_clk) disable iff (!arst_n)
        susp_ev |=> s_q.common_flags[usb_susp_pkg::cm_suspend_bit];
    endproperty
    a_susp_flag: assert property (p_susp_flag) else $error("suspend flag lost");

    property p_no_susp_enter;
        @(posedge core_clk) disable iff (!arst_n)
        (!s_q.detect_en && !s_q.suspended) |=> !s_q.suspended;
    endproperty
    a_no_susp_enter: assert property (p_no_susp_enter) else $error("suspended while off");

    property p_susp_hold;
        @(posedge core_clk) disable iff (!arst_n)
        (s_q.suspended && !wr && !rd_common) |=> s_q.suspended;
    endproperty
    a_susp_hold: assert property (p_susp_hold) else $error("suspend left early");

    property p_susp_cause;
        @(posedge core_clk) disable iff (!arst_n)
        $rose(s_q.suspended) |-> $past(susp_ev);
    endproperty
    a_susp_cause: assert property (p_susp_cause) else $error("suspend without cause");

    property p_drive_needs_susp;
        @(posedge core_clk) disable iff (!arst_n)
        resume_drive |-> s_q.suspended;
    endproperty
    a_drive_needs_susp: assert property (p_drive_needs_susp) else $error("resume outside suspend");

    property p_drive_set;
        @(posedge core_clk) disable iff (!arst_n)
        (wr && paddr == usb_susp_pkg::power_off && pwdata[usb_susp_pkg::power_resume_bit]
         && s_q.suspended) |=> resume_drive;
    endproperty
    a_drive_set: assert property (p_drive_set) else $error("resume not driven");

    property p_inhibit_stays_low;
        @(posedge core_clk) disable iff (!arst_n)
        !s_q.inhibit |=> !s_q.inhibit;
    endproperty
    a_inhibit_stays_low: assert property (p_inhibit_stays_low) else $error("inhibit set");

    property p_inhibit_clear;
        @(posedge core_clk) disable iff (!arst_n)
        (wr && paddr == usb_susp_pkg::power_off && !pwdata[usb_susp_pkg::power_inhibit_bit])
            |=> !controller_inhibit;
    endproperty
    a_inhibit_clear: assert property (p_inhibit_clear) else $error("inhibit kept");

    property p_irq_hold;
        @(posedge core_clk) disable iff (!arst_n)
        ((|(s_q.irq_status & s_q.irq_mask)) && !wr) |=> irq;
    endproperty
    a_irq_hold: assert property (p_irq_hold) else $error("irq dropped");

    property p_irq_quiet;
        @(posedge core_clk) disable iff (!arst_n)
        (s_q.irq_status == 2'b00 && !susp_ev && !res_ev) |=> !irq;
    endproperty
    a_irq_quiet: assert property (p_irq_quiet) else $error("irq without status");

    property p_status_w1c;
        @(posedge core_clk) disable iff (!arst_n)
        (wr && paddr == usb_susp_pkg::irq_status_off && !susp_ev && !res_ev)
            |=> (s_q.irq_status & $past(pwdata[1:0])) == 2'b00;
    endproperty
    a_status_w1c: assert property (p_status_w1c) else $error("status not cleared");

    property p_status_susp;
        @(posedge core_clk) disable iff (!arst_n)
        susp_ev |=> s_q.irq_status[usb_susp_pkg::cm_suspend_bit];
    endproperty
    a_status_susp: assert property (p_status_susp) else $error("suspend status lost");

    property p_usb_irq_common;
        @(posedge core_clk) disable iff (!arst_n)
        ((|s_q.common_flags) && cpu_extended_irq_enable && !rd_common) |=> usb_irq;
    endproperty
    a_usb_irq_common: assert property (p_usb_irq_common) else $error("usb irq missing");

    property p_usb_irq_quiet;
        @(posedge core_clk) disable iff (!arst_n)
        (s_q.in_flags == 4'h0 && s_q.common_flags == 2'b00 && !susp_ev && !res_ev
         && (s_q.inhibit || link_in.in_events == 4'h0)) |=> !usb_irq;
    endproperty
    a_usb_irq_quiet: assert property (p_usb_irq_quiet) else $error("usb irq spurious");

    property p_resume_needs_susp;
        @(posedge core_clk) disable iff (!arst_n)
        !s_q.suspended |=> !$rose(s_q.common_flags[usb_susp_pkg::cm_resume_bit]);
    endproperty
    a_resume_needs_susp: assert property (p_resume_needs_susp) else $error("resume flag awake");

    property p_power_data;
        @(posedge core_clk) disable iff (!arst_n)
        (rd && paddr == usb_susp_pkg::power_off)
            |=> prdata[usb_susp_pkg::power_susp_bit] == $past(s_q.suspended)
                && prdata[usb_susp_pkg::power_inhibit_bit] == $past(s_q.inhibit);
    endproperty
    a_power_data: assert property (p_power_data) else $error("power data");

    property p_detect_write;
        @(posedge core_clk) disable iff (!arst_n)
        (wr && paddr == usb_susp_pkg::power_off)
            |=> s_q.detect_en == $past(pwdata[usb_susp_pkg::power_detect_bit]);
    endproperty
    a_detect_write: assert property (p_detect_write) else $error("detect enable");
endmodule

// >>> usb_host_model.sv
module usb_host_model (
    input  wire logic              core_clk,
    output usb_susp_pkg::link_in_t link_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial link_in = '0;
    // one-cycle bus event; frame field is scrambled after, never left stale
    task automatic send(input logic s, input logic r, input logic [10:0] f, input logic [3:0] e);
        @(posedge core_clk);
        link_in <= '{s, r, f != 11'h000, f, e};
        @(posedge core_clk);
        link_in <= '{1'b0, 1'b0, 1'b0, ~f, 4'h0};
    endtask
endmodule

// >>> usb_suspend_frame_irq_flags_bench.sv
module usb_suspend_frame_irq_flags_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic                   core_clk = 0;
    logic                   arst_n   = 0;
    logic                   psel     = 0;
    logic                   penable  = 0;
    logic                   pwrite   = 0;
    logic [11:0]            paddr    = 12'h000;
    logic [31:0]            pwdata   = 32'h0000_0000;
    logic [31:0]            prdata;
    logic                   pready;
    logic                   pslverr;
    logic                   cpu_en   = 0;
    logic                   usb_irq;
    logic                   resume_drive;
    logic                   inhibit;
    logic                   irq;
    logic                   err;
    logic [31:0]            r;
    usb_susp_pkg::link_in_t link_in;
    int                     fails   = 0;
    int                     checked = 0;
    usb_host_model usb_host_model_i (.core_clk(core_clk), .link_in(link_in));
    usb_susp_frame_irq usb_susp_frame_irq_i (.core_clk(core_clk), .arst_n(arst_n),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .link_in(link_in),
        .cpu_extended_irq_enable(cpu_en), .usb_irq(usb_irq), .resume_drive(resume_drive),
        .controller_inhibit(inhibit), .irq(irq));
    initial begin
        forever #5 core_clk = ~core_clk;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, s);
            fails++;
        end
    endtask
    // waits for pready; only the watchdog ends a wait on a dead slave
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        r = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rc(input string nm, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000);
        chk(nm, e, r);
    endtask
    task automatic t_reset;
        rc("power", usb_susp_pkg::power_off, 32'h0000_0010);
        rc("frame_low", usb_susp_pkg::frame_low_off, 32'h0000_0000);
        rc("frame_high", usb_susp_pkg::frame_high_off, 32'h0000_0000);
        rc("in_flags", usb_susp_pkg::in_flags_off, 32'h0000_0000);
        $display("reset test done");
    endtask
    task automatic t_frame;
        apb(1'b1, usb_susp_pkg::power_off, 32'h0000_0000);
        chk("inhibit", 32'h0000_0000, {31'h0, inhibit});
        usb_host_model_i.send(1'b0, 1'b0, 11'h5a3, 4'h0);
        rc("frame_low", usb_susp_pkg::frame_low_off, 32'h0000_00a3);
        apb(1'b1, usb_susp_pkg::frame_high_off, 32'hffff_ffff);
        rc("frame_high", usb_susp_pkg::frame_high_off, 32'h0000_0005);
        $display("frame test done");
    endtask
    task automatic t_flags;
        cpu_en <= 1'b1;
        usb_host_model_i.send(1'b0, 1'b0, 11'h000, 4'hb);
        repeat (2) @(posedge core_clk);
        chk("usb_irq on", 32'h0000_0001, {31'h0, usb_irq});
        cpu_en <= 1'b0;
        repeat (2) @(posedge core_clk);
        chk("usb_irq gated", 32'h0000_0000, {31'h0, usb_irq});
        apb(1'b1, usb_susp_pkg::in_flags_off, 32'h0000_0004);
        rc("in_flags", usb_susp_pkg::in_flags_off, 32'h0000_000b);
        rc("in_flags cleared", usb_susp_pkg::in_flags_off, 32'h0000_0000);
        rc("unmapped data", 12'h0fc, 32'h0000_0000);
        chk("unmapped err", 32'h0000_0001, {31'h0, err});
        $display("flag test done");
    endtask
    task automatic t_suspend;
        usb_host_model_i.send(1'b1, 1'b0, 11'h000, 4'h0);
        rc("power", usb_susp_pkg::power_off, 32'h0000_0000);
        rc("common", usb_susp_pkg::common_flags_off, 32'h0000_0000);
        apb(1'b1, usb_susp_pkg::power_off, 32'h0000_0001);
        usb_host_model_i.send(1'b1, 1'b0, 11'h000, 4'h0);
        rc("power", usb_susp_pkg::power_off, 32'h0000_0003);
        rc("common", usb_susp_pkg::common_flags_off, 32'h0000_0001);
        apb(1'b1, usb_susp_pkg::power_off, 32'h0000_0005);
        chk("resume_drive", 32'h0000_0001, {31'h0, resume_drive});
        // resume held a few cycles, not ms: the block does not time it
        apb(1'b1, usb_susp_pkg::power_off, 32'h0000_0001);
        chk("resume_drive off", 32'h0000_0000, {31'h0, resume_drive});
        rc("power", usb_susp_pkg::power_off, 32'h0000_0001);
        $display("suspend test done");
    endtask
    task automatic t_resume;
        apb(1'b1, usb_susp_pkg::irq_status_off, 32'h0000_0003);
        apb(1'b1, usb_susp_pkg::irq_mask_off, 32'h0000_0003);
        chk("irq idle", 32'h0000_0000, {31'h0, irq});
        usb_host_model_i.send(1'b1, 1'b0, 11'h000, 4'h0);
        @(posedge core_clk);
        chk("irq", 32'h0000_0001, {31'h0, irq});
        apb(1'b1, usb_susp_pkg::irq_status_off, 32'h0000_0003);
        @(posedge core_clk);
        chk("irq cleared", 32'h0000_0000, {31'h0, irq});
        usb_host_model_i.send(1'b0, 1'b1, 11'h000, 4'h0);
        rc("common", usb_susp_pkg::common_flags_off, 32'h0000_0003);
        rc("power", usb_susp_pkg::power_off, 32'h0000_0001);
        rc("irq_status", usb_susp_pkg::irq_status_off, 32'h0000_0002);
        rc("irq_mask", usb_susp_pkg::irq_mask_off, 32'h0000_0003);
        $display("resume test done");
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #50000;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (8) @(posedge core_clk);
        arst_n <= 1'b1;
        t_reset();
        t_frame();
        t_flags();
        t_suspend();
        t_resume();
        report_and_stop();
    end
endmodule
